// [rtl/lfs_map.svh]
/*
 * Constants of the fault status block: APB offsets, field positions inside
 * the 288-bit fault status word, reset values and self-test codes.
 * Assumes it is included by bare name by every file that needs a number.
 */
`ifndef LFS_MAP_SVH
`define LFS_MAP_SVH

// Notes on behaviour
// RULE1 - Bits 287:280 hold the second open check of the blue channels, 1 is a fault.
// RULE2 - Bits 271:264 hold the second open check of the red channels, 1 is a fault.
// RULE3 - Bits 263:256 hold the first open check of the blue channels, 1 is a fault.
// RULE4 - Bits 247:240 hold the first open check of the red channels, 1 is a fault.
// RULE5 - Bits 239:232 hold the neighbour short results of the blue channels.
// RULE6 - Bits 231:224 hold unused pin neighbour shorts, lowest pin in bit 231.
// RULE7 - Bits 223:216 hold the neighbour short results of the red channels.
// RULE8 - Bits 213:211 read 3h when the neighbour short self-test passes, 6h on failure.
// RULE9 - Bits 208:206 read 3h when the open/short self-test passes, 6h on failure.
// RULE10 - Bits 191:184 hold the second short check of the blue channels.
// RULE11 - Bits 175:168 hold the second short check of the red channels.
// RULE12 - Bits 167:160 hold the first short check of the blue channels.
// RULE13 - Bits 151:144 hold the first short check of the red channels.
// RULE14 - Bits 215, 214, 210 and 209 flag thermal error, thermal warning, resistor short, open.
// RULE15 - Bits 205 and 204 echo the two negate-toggle values.
// RULE16 - All fields are read-only, zero after reset, and reserved bits read zero.

// --------------------------------------------------------------------
// APB offsets
// --------------------------------------------------------------------
`define LFS_OFS_STATUS_FIRST 8'h00
`define LFS_OFS_STATUS_LAST  8'h20
`define LFS_OFS_CTRL         8'h24

// --------------------------------------------------------------------
// Control fields
// --------------------------------------------------------------------
`define LFS_CTRL_HOLD_BIT  0
`define LFS_CTRL_CLEAR_BIT 1

// --------------------------------------------------------------------
// Low bit of each field of the fault status word
// --------------------------------------------------------------------
`define LFS_POS_BLUE_OPEN_TWO  280
`define LFS_POS_RED_OPEN_TWO   264
`define LFS_POS_BLUE_OPEN_ONE  256
`define LFS_POS_RED_OPEN_ONE   240
`define LFS_POS_BLUE_NSHORT    232
`define LFS_POS_UNUSED_NSHORT  224
`define LFS_POS_RED_NSHORT     216
`define LFS_POS_THERMAL_ERROR  215
`define LFS_POS_THERMAL_WARN   214
`define LFS_POS_NSHORT_CODE    211
`define LFS_POS_RREF_SHORT     210
`define LFS_POS_RREF_OPEN      209
`define LFS_POS_OS_CODE        206
`define LFS_POS_NEG_HIGH       205
`define LFS_POS_NEG_LOW        204
`define LFS_POS_BLUE_SHORT_TWO 184
`define LFS_POS_RED_SHORT_TWO  168
`define LFS_POS_BLUE_SHORT_ONE 160
`define LFS_POS_RED_SHORT_ONE  144

// --------------------------------------------------------------------
// Self-test codes and reset values
// --------------------------------------------------------------------
`define LFS_CODE_IDLE   3'h0
`define LFS_CODE_PASS   3'h3
`define LFS_CODE_FAIL   3'h6
`define LFS_RST_STATUS  288'h0
`define LFS_RST_RDATA   32'h0
`define LFS_RST_HOLD    1'h0

`endif

// [rtl/lfs_pkg.sv]
/*
 * Types of the fault status block: the carriers of fault results and of
 * self-test results. Assumes nothing beyond a SystemVerilog compiler.
 */
package lfs_pkg;

    // Per-channel results, bit 7 is channel 7; for unused pins bit 7 is
    // the lowest-numbered pin.
    typedef struct packed {
        logic [7:0] blue_open_check_two;
        logic [7:0] red_open_check_two;
        logic [7:0] blue_open_check_one;
        logic [7:0] red_open_check_one;
        logic [7:0] blue_neighbour_short;
        logic [7:0] unused_pin_neighbour_short;
        logic [7:0] red_neighbour_short;
        logic [7:0] blue_short_check_two;
        logic [7:0] red_short_check_two;
        logic [7:0] blue_short_check_one;
        logic [7:0] red_short_check_one;
        logic       thermal_error_flag;
        logic       thermal_warning_flag;
        logic       ref_resistor_short_flag;
        logic       ref_resistor_open_flag;
    } lfs_fault_type;

    // Self-test outcomes as levels, and the negate-toggle values.
    typedef struct packed {
        logic nshort_done;
        logic nshort_fail;
        logic os_done;
        logic os_fail;
        logic negate_toggle_high;
        logic negate_toggle_low;
    } lfs_selftest_type;

endpackage

// [rtl/lfs_sync.sv]
/*
 * Two-flop synchroniser of a vector of independent levels.
 * Assumes each bit is a slow level; a multi-bit value is not kept coherent.
 */
`timescale 1ns/1ns

module lfs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clock,
    input  wire logic             i_nrst,
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] meta;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            meta <= '0;
            o_q  <= '0;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end

endmodule

// [rtl/lfs_latch.sv]
/*
 * Bank of fault flags that either follow their source or hold it sticky.
 * Assumes set and clear come from the same clock domain.
 */
`timescale 1ns/1ns

module lfs_latch #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clock,
    input  wire logic             i_nrst,
    input  wire logic             i_hold,
    input  wire logic             i_clear,
    input  wire logic [WIDTH-1:0] i_set,
    output logic      [WIDTH-1:0] o_flag
);

    // ----------------------------------------------------------------
    // One flag per bit
    // ----------------------------------------------------------------
    for (genvar g = 0; g < WIDTH; g++) begin : g_flag
        logic next_flag;

        // A fault in the clearing cycle survives the clear.
        assign next_flag = i_hold ? ((o_flag[g] & ~i_clear) | i_set[g]) : i_set[g];

        always_ff @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
                o_flag[g] <= 1'b0;
            end else begin
                o_flag[g] <= next_flag;
            end
        end
    end

endmodule

// [rtl/lfs_status_top.sv]
/*
 * Fault status word of a 16-channel LED sink driver, read over APB as
 * nine words, plus one control word that picks live or sticky reporting.
 * Assumes the fault and self-test inputs are levels from detector logic
 * on other clocks; they are synchronised here before use.
 */
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "lfs_map.svh"

module lfs_status_top (
    input  wire logic                       I_CLOCK,
    input  wire logic                       I_NRST,
    input  wire logic                       I_PSEL,
    input  wire logic                       I_PENABLE,
    input  wire logic                       I_PWRITE,
    input  wire logic [7:0]                 I_PADDR,
    input  wire logic [31:0]                I_PWDATA,
    input  wire logic [3:0]                 I_PSTRB,
    input  wire lfs_pkg::lfs_fault_type     I_FAULTS,
    input  wire lfs_pkg::lfs_selftest_type  I_SELFTEST,
    output logic      [31:0]                O_PRDATA,
    output logic                            O_PREADY,
    output logic                            O_PSLVERR
);

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------

    // True for an aligned word of the fault status word.
    function automatic logic lfs_is_status(input logic [7:0] addr);
        return (addr[1:0] == 2'h0) && (addr <= `LFS_OFS_STATUS_LAST);
    endfunction

    // True for the control word.
    function automatic logic lfs_is_ctrl(input logic [7:0] addr);
        return addr == `LFS_OFS_CTRL;
    endfunction

    // Self-test code: idle until the test has run, then pass or fail.
    function automatic logic [2:0] lfs_code(input logic done, input logic fail);
        return !done ? `LFS_CODE_IDLE : (fail ? `LFS_CODE_FAIL : `LFS_CODE_PASS);
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    lfs_pkg::lfs_fault_type    live_faults;
    lfs_pkg::lfs_fault_type    held_faults;
    lfs_pkg::lfs_selftest_type live_test;
    logic [2:0]                nshort_code;
    logic [2:0]                os_code;
    logic [2:0]                next_nshort_code;
    logic [2:0]                next_os_code;
    logic [287:0]              status_word;
    logic [8:0][31:0]          status_words;
    logic [31:0]               ctrl_readback;
    logic [31:0]               read_word;
    logic                      ctrl_hold;
    logic                      clear_pulse;
    logic                      next_ctrl_hold;
    logic                      next_clear_pulse;
    logic                      access;
    logic                      take;
    logic                      ctrl_wr;
    logic                      bad_access;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
    logic                      next_pready;
    logic                      next_pslverr;
    logic [31:0]               next_prdata;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------

    // Detector results change on their own clocks, so each level is
    // brought in through two flops before anything looks at it.
    lfs_sync #(
        .WIDTH ($bits(lfs_pkg::lfs_fault_type))
    ) u_sync_faults (
        .i_clock (I_CLOCK),
        .i_nrst  (I_NRST),
        .i_d     (I_FAULTS),
        .o_q     (live_faults)
    );

    lfs_sync #(
        .WIDTH ($bits(lfs_pkg::lfs_selftest_type))
    ) u_sync_test (
        .i_clock (I_CLOCK),
        .i_nrst  (I_NRST),
        .i_d     (I_SELFTEST),
        .o_q     (live_test)
    );

    // ----------------------------------------------------------------
    // Fault flags
    // ----------------------------------------------------------------

    // In hold mode a short glitch of a detector stays visible until
    // software clears it; otherwise the word tracks the detectors.
    lfs_latch #(
        .WIDTH ($bits(lfs_pkg::lfs_fault_type))
    ) u_latch (
        .i_clock (I_CLOCK),
        .i_nrst  (I_NRST),
        .i_hold  (ctrl_hold),
        .i_clear (clear_pulse),
        .i_set   (live_faults),
        .o_flag  (held_faults)
    );

    // ----------------------------------------------------------------
    // Self-test codes
    // ----------------------------------------------------------------
    assign next_nshort_code = lfs_code(live_test.nshort_done, live_test.nshort_fail); // RULE8
    assign next_os_code     = lfs_code(live_test.os_done, live_test.os_fail); // RULE9

    // Codes are registered so that a read never sees a half-changed field.
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            nshort_code <= `LFS_CODE_IDLE;
            os_code     <= `LFS_CODE_IDLE;
        end else begin
            nshort_code <= next_nshort_code;
            os_code     <= next_os_code;
        end
    end

    // ----------------------------------------------------------------
    // Fault status word
    // ----------------------------------------------------------------

    // Every bit not written below stays zero, which keeps reserved ranges clear.
    always_comb begin
        status_word = `LFS_RST_STATUS; // RULE16
        status_word[`LFS_POS_BLUE_OPEN_TWO +: 8]  = held_faults.blue_open_check_two; // RULE1
        status_word[`LFS_POS_RED_OPEN_TWO +: 8]   = held_faults.red_open_check_two; // RULE2
        status_word[`LFS_POS_BLUE_OPEN_ONE +: 8]  = held_faults.blue_open_check_one; // RULE3
        status_word[`LFS_POS_RED_OPEN_ONE +: 8]   = held_faults.red_open_check_one; // RULE4
        status_word[`LFS_POS_BLUE_NSHORT +: 8]    = held_faults.blue_neighbour_short; // RULE5
        status_word[`LFS_POS_UNUSED_NSHORT +: 8]  =
            held_faults.unused_pin_neighbour_short; // RULE6
        status_word[`LFS_POS_RED_NSHORT +: 8]     = held_faults.red_neighbour_short; // RULE7
        status_word[`LFS_POS_THERMAL_ERROR]       = held_faults.thermal_error_flag; // RULE14
        status_word[`LFS_POS_THERMAL_WARN]        = held_faults.thermal_warning_flag; // RULE14
        status_word[`LFS_POS_NSHORT_CODE +: 3]    = nshort_code; // RULE8
        status_word[`LFS_POS_RREF_SHORT]          = held_faults.ref_resistor_short_flag; // RULE14
        status_word[`LFS_POS_RREF_OPEN]           = held_faults.ref_resistor_open_flag; // RULE14
        status_word[`LFS_POS_OS_CODE +: 3]        = os_code; // RULE9
        status_word[`LFS_POS_NEG_HIGH]            = live_test.negate_toggle_high; // RULE15
        status_word[`LFS_POS_NEG_LOW]             = live_test.negate_toggle_low; // RULE15
        status_word[`LFS_POS_BLUE_SHORT_TWO +: 8] = held_faults.blue_short_check_two; // RULE10
        status_word[`LFS_POS_RED_SHORT_TWO +: 8]  = held_faults.red_short_check_two; // RULE11
        status_word[`LFS_POS_BLUE_SHORT_ONE +: 8] = held_faults.blue_short_check_one; // RULE12
        status_word[`LFS_POS_RED_SHORT_ONE +: 8]  = held_faults.red_short_check_one; // RULE13
    end

    // Word n of the bus carries bits 32n+31 down to 32n.
    assign status_words = status_word;

    // Only the hold bit reads back; the clear bit is a strobe and reads zero.
    always_comb begin
        ctrl_readback = `LFS_RST_RDATA;
        ctrl_readback[`LFS_CTRL_HOLD_BIT] = ctrl_hold;
    end

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign access     = I_PSEL & I_PENABLE;
    assign take       = access & ~pready;
    assign read_word  = lfs_is_status(I_PADDR) ? status_words[I_PADDR[5:2]] :
                        lfs_is_ctrl(I_PADDR)   ? ctrl_readback : `LFS_RST_RDATA;
    // The status word is read-only, so a write to it is answered with an error.
    assign bad_access = ~lfs_is_ctrl(I_PADDR) &
                        ~(lfs_is_status(I_PADDR) & ~I_PWRITE); // RULE16
    // A write lands at the edge where the master sees the ready answer.
    assign ctrl_wr    = access & pready & I_PWRITE & I_PSTRB[0] & lfs_is_ctrl(I_PADDR);

    assign next_pready  = take;
    assign next_pslverr = take & bad_access;
    assign next_prdata  = (take & ~I_PWRITE) ? read_word : `LFS_RST_RDATA;

    // ----------------------------------------------------------------
    // APB answer registers
    // ----------------------------------------------------------------

    // One wait state keeps the read mux off the output path.
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `LFS_RST_RDATA;
        end else begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    assign O_PREADY  = pready;
    assign O_PSLVERR = pslverr;
    assign O_PRDATA  = prdata;

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    assign next_ctrl_hold   = ctrl_wr ? I_PWDATA[`LFS_CTRL_HOLD_BIT] : ctrl_hold;
    assign next_clear_pulse = ctrl_wr & I_PWDATA[`LFS_CTRL_CLEAR_BIT];

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            ctrl_hold   <= `LFS_RST_HOLD;
            clear_pulse <= 1'b0;
        end else begin
            ctrl_hold   <= next_ctrl_hold;
            clear_pulse <= next_clear_pulse;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_NRST);

    property p_rule1_live;
        !ctrl_hold |=> status_word[287:280] == $past(live_faults.blue_open_check_two);
    endproperty
    a_rule1_live: assert property (p_rule1_live) // RULE1
        else $error("blue second open check not in bits 287:280");

    property p_rule1_read;
        take && !I_PWRITE && I_PADDR == `LFS_OFS_STATUS_LAST
            |=> O_PREADY && O_PRDATA[31:24] == $past(status_word[287:280]);
    endproperty
    a_rule1_read: assert property (p_rule1_read) // RULE1
        else $error("top status word read returned wrong data");

    property p_rule3_live;
        !ctrl_hold ##1 !ctrl_hold |-> status_word[263:256] ==
            $past(live_faults.blue_open_check_one);
    endproperty
    a_rule3_live: assert property (p_rule3_live) // RULE3
        else $error("blue first open check not in bits 263:256");

    property p_rule6_order;
        !ctrl_hold |=> status_word[231] == $past(live_faults.unused_pin_neighbour_short[7])
            && status_word[224] == $past(live_faults.unused_pin_neighbour_short[0]);
    endproperty
    a_rule6_order: assert property (p_rule6_order) // RULE6
        else $error("unused pin order wrong in bits 231:224");

    property p_rule8_code;
        live_test.nshort_done |=>
            status_word[213:211] == ($past(live_test.nshort_fail) ? 3'h6 : 3'h3);
    endproperty
    a_rule8_code: assert property (p_rule8_code) // RULE8
        else $error("neighbour short self-test code wrong");

    property p_rule9_code;
        (live_test.os_done && live_test.os_fail)[*2] |-> status_word[208:206] == 3'h6;
    endproperty
    a_rule9_code: assert property (p_rule9_code) // RULE9
        else $error("open short self-test fail code wrong");

    property p_rule12_live;
        !ctrl_hold |=> status_word[167:160] == $past(live_faults.blue_short_check_one);
    endproperty
    a_rule12_live: assert property (p_rule12_live) // RULE12
        else $error("blue first short check not in bits 167:160");

    property p_rule14_thermal;
        !ctrl_hold && live_faults.thermal_error_flag |=> status_word[215];
    endproperty
    a_rule14_thermal: assert property (p_rule14_thermal) // RULE14
        else $error("thermal error flag not at bit 215");

    property p_rule15_negate;
        status_word[205:204] == {live_test.negate_toggle_high, live_test.negate_toggle_low};
    endproperty
    a_rule15_negate: assert property (p_rule15_negate) // RULE15
        else $error("negate toggle values not at bits 205:204");

    property p_rule16_reserved;
        status_word[279:272] == 8'h00 && status_word[203:192] == 12'h000
            && status_word[143:0] == 144'h0;
    endproperty
    a_rule16_reserved: assert property (p_rule16_reserved) // RULE16
        else $error("reserved status bits not zero");

    property p_rule16_readonly;
        take && I_PWRITE && lfs_is_status(I_PADDR) |=> O_PREADY && O_PSLVERR
            ##1 $stable(status_word);
    endproperty
    a_rule16_readonly: assert property (p_rule16_readonly) // RULE16
        else $error("write to status word not refused");

    property p_sticky_set_wins;
        ctrl_hold && clear_pulse && live_faults.red_neighbour_short[0]
            |=> status_word[216];
    endproperty
    a_sticky_set_wins: assert property (p_sticky_set_wins)
        else $error("fault lost in clearing cycle");

    property p_answer_once;
        take |=> O_PREADY ##1 !O_PREADY;
    endproperty
    a_answer_once: assert property (p_answer_once)
        else $error("ready not a single cycle after one wait state");

endmodule

// [bench/lfs_host_model.sv]
/*
 * APB host model that reads and writes the fault status block.
 * Assumes one clock shared with the block and a slave that answers in time.
 */
`timescale 1ns/1ns

module lfs_host_model (
    input  wire logic        i_clock,
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr,
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic      [7:0]  o_paddr,
    output logic      [31:0] o_pwdata,
    output logic      [3:0]  o_pstrb
);
    initial begin
        o_psel    = 1'b0;
        o_penable = 1'b0;
        o_pwrite  = 1'b0;
        o_paddr   = 8'h00;
        o_pwdata  = 32'h0;
        o_pstrb   = 4'h0;
    end

    // One transfer; the request is held until pready is seen at a rising edge.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge i_clock);
        o_psel   <= 1'b1;
        o_pwrite <= w;
        o_paddr  <= a;
        o_pwdata <= d;
        o_pstrb  <= 4'hF;
        @(posedge i_clock);
        o_penable <= 1'b1;
        do @(posedge i_clock); while (i_pready !== 1'b1);
        rd = i_prdata;
        err = i_pslverr;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
    endtask
endmodule

// [bench/tb_top.sv]
/*
 * Self-checking bench of the fault status block: field layout, self-test
 * codes, reset values, refusals and sticky reporting.
 * Assumes the block answers APB with one wait state and syncs its inputs.
 */
`timescale 1ns/1ns

module tb_top;
    logic                      clk;
    logic                      nrst;
    lfs_pkg::lfs_fault_type    faults;
    lfs_pkg::lfs_selftest_type st;
    logic psel, pen, pwr, rdy, perr, err;
    logic [7:0]  addr;
    logic [31:0] wd, prd, rd;
    logic [3:0]  strb;
    logic [91:0] rows_f [4] = '{92'hFFFFFFFFFFFFFFFFFFFFFFF, 92'hAAAAAAAAAAAAAAAAAAAAAAA,
                                92'h55555555555555555555555, 92'h0123456789ABCDEF0FEDCBA};
    logic [5:0]  rows_s [4] = '{6'h3F, 6'h2A, 6'h15, 6'h26};
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;

    lfs_status_top DUT (.I_CLOCK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(addr), .I_PWDATA(wd), .I_PSTRB(strb), .I_FAULTS(faults),
        .I_SELFTEST(st), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(perr));
    lfs_host_model HOST (.i_clock(clk), .i_prdata(prd), .i_pready(rdy), .i_pslverr(perr),
        .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(addr), .o_pwdata(wd),
        .o_pstrb(strb));

    // --------------------------------------------------------------------
    // Clock and timeout
    // --------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // A hang is cut short well beyond the few hundred cycles the tests need.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            wrap_up();
        end
    end

    // Expected status word built from the field layout.
    function automatic logic [287:0] exp_word(lfs_pkg::lfs_fault_type f,
                                              lfs_pkg::lfs_selftest_type s);
        logic [287:0] e;
        e = '0;
        e[287:280] = f.blue_open_check_two;
        e[271:264] = f.red_open_check_two;
        e[263:256] = f.blue_open_check_one;
        e[247:240] = f.red_open_check_one;
        e[239:232] = f.blue_neighbour_short;
        e[231:224] = f.unused_pin_neighbour_short;
        e[223:216] = f.red_neighbour_short;
        e[215] = f.thermal_error_flag;
        e[214] = f.thermal_warning_flag;
        e[213:211] = s.nshort_done ? (s.nshort_fail ? 3'h6 : 3'h3) : 3'h0;
        e[210] = f.ref_resistor_short_flag;
        e[209] = f.ref_resistor_open_flag;
        e[208:206] = s.os_done ? (s.os_fail ? 3'h6 : 3'h3) : 3'h0;
        e[205] = s.negate_toggle_high;
        e[204] = s.negate_toggle_low;
        e[191:184] = f.blue_short_check_two;
        e[175:168] = f.red_short_check_two;
        e[167:160] = f.blue_short_check_one;
        e[151:144] = f.red_short_check_one;
        return e;
    endfunction

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex) begin
            $display("Error %s expected %h seen %h", nm, ex, got);
            n_errors++;
        end
    endtask

    // Reads all nine words and compares them with the expected word.
    task automatic read_all(input logic [287:0] e);
        for (int w = 0; w < 9; w++) begin
            HOST.xfer(1'b0, 8'(w * 4), 32'h0, rd, err);
            chk("status word", e[32*w+:32], rd);
            chk("read error", 32'h0, {31'h0, err});
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // --------------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        faults = '0;
        st = '0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        read_all('0);
        $display("Test reset values done");
        for (int r = 0; r < 4; r++) begin
            faults <= rows_f[r];
            st <= rows_s[r];
            repeat (4) @(posedge clk);
            read_all(exp_word(rows_f[r], rows_s[r]));
        end
        $display("Test field table done");
        HOST.xfer(1'b1, 8'h00, 32'hFFFFFFFF, rd, err);
        chk("status write error", 32'h1, {31'h0, err});
        HOST.xfer(1'b0, 8'h28, 32'h0, rd, err);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        read_all(exp_word(rows_f[3], rows_s[3]));
        $display("Test refusals done");
        HOST.xfer(1'b1, 8'h24, 32'h1, rd, err);
        HOST.xfer(1'b0, 8'h24, 32'h0, rd, err);
        chk("hold readback", 32'h1, rd);
        faults <= '1;
        repeat (4) @(posedge clk);
        // A clear while the faults still stand must leave them set.
        HOST.xfer(1'b1, 8'h24, 32'h3, rd, err);
        faults <= '0;
        repeat (4) @(posedge clk);
        HOST.xfer(1'b0, 8'h20, 32'h0, rd, err);
        chk("sticky word", 32'hFF00FFFF, rd);
        HOST.xfer(1'b1, 8'h24, 32'h3, rd, err);
        repeat (2) @(posedge clk);
        HOST.xfer(1'b0, 8'h20, 32'h0, rd, err);
        chk("cleared word", 32'h0, rd);
        $display("Test sticky flags done");
        // A reset in mid-run must drop the hold bit and every fault field.
        HOST.xfer(1'b1, 8'h24, 32'h1, rd, err);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        HOST.xfer(1'b0, 8'h24, 32'h0, rd, err);
        chk("hold after reset", 32'h0, rd);
        read_all(exp_word('0, rows_s[3]));
        $display("Test mid-run reset done");
        wrap_up();
    end
endmodule
